// File: design/gtc_pkg.sv
// holds the constants, register map, field layouts and types of the gated
// 16-bit timer/counter; assumes a 32-bit APB slave clocked by pclk.

package gtc_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] GTC_TIMER_CONTROL_OFS = 12'h000;
	localparam logic [11:0] GTC_GATE_CONTROL_OFS = 12'h004;
	localparam logic [11:0] GTC_COUNT_LOW_OFS = 12'h008;
	localparam logic [11:0] GTC_COUNT_HIGH_OFS = 12'h00C;
	localparam logic [11:0] GTC_STATUS_OFS = 12'h010;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GTC_ON_POS = 0; // timer on bit
	localparam int GTC_SYNC_POS = 2; // sync control bit
	localparam int GTC_PS_POS = 4; // prescale select, 2 bits
	localparam int GTC_CS_POS = 6; // clock source, 2 bits
	localparam int GTC_GSS_POS = 0; // gate source, 2 bits
	localparam int GTC_GVAL_POS = 2; // gate value, read only
	localparam int GTC_GTM_POS = 5; // toggle mode bit
	localparam int GTC_GPOL_POS = 6; // gate polarity bit
	localparam int GTC_GE_POS = 7; // gate enable bit
	localparam int GTC_OVF_POS = 0; // overflow flag in status

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] GTC_CTRL_RESET = 8'h00;
	localparam logic [15:0] GTC_COUNT_RESET = 16'h0000;
	localparam logic [15:0] GTC_COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] GTC_BYTE_MAX = 8'hFF;
	localparam logic [7:0] GTC_BYTE_ZERO = 8'h00;
	localparam logic [1:0] GTC_INSTR_DIV_LAST = 2'h3; // fosc/4 phase

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GTC_CS_INSTR = 2'b00,
		GTC_CS_SYSTEM = 2'b01,
		GTC_CS_EXTERNAL = 2'b10,
		GTC_CS_LFOSC = 2'b11
	} gtc_clk_src_type;

	typedef enum logic [1:0] {
		GTC_GS_PIN = 2'b00,
		GTC_GS_BYTE_OVF = 2'b01,
		GTC_GS_CMP1 = 2'b10,
		GTC_GS_CMP2 = 2'b11
	} gtc_gate_src_type;

	// gate source inputs travel together
	typedef struct packed {
		logic gate_pin;
		logic comparator1_output;
		logic comparator2_output;
		logic [7:0] byte_timer_count;
	} gtc_gate_in_type;

endpackage : gtc_pkg

// File: design/gtc_timer.sv
// holds the gated 16-bit timer/counter with its APB register file.
// assumes every input is synchronous to pclk except the gate pin, which
// is resynchronised here; the external clock pin is sampled by pclk.
//
// The register addresses and register access over APB are this design's own decisions.

`timescale 1ns/10ps

module gtc_timer
	import gtc_pkg::*;
(
	// clock, reset and freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock sources
	input wire logic external_clock_input,
	input wire logic low_freq_internal_osc,
	input wire logic sleep_mode,
	// gate sources
	input wire gtc_gate_in_type gate_in,
	// status out
	output logic overflow_flag,
	output logic [15:0] count_value
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] timer_control_reg; // software control of clocking
	logic [7:0] gate_control_reg; // writable gate bits only
	logic [15:0] count_reg; // the counter pair
	logic [15:0] count_next; // incremented count
	logic ovf_reg; // sticky overflow flag
	logic [2:0] presc_reg; // hidden prescale counter
	logic [1:0] instr_div_reg; // fosc/4 phase counter
	logic ext_s1_reg; // external sync stage 1
	logic ext_s2_reg; // external sync stage 2
	logic ext_a_reg; // external direct capture
	logic ext_prev_reg; // previous chosen level
	logic need_fall_reg; // waiting for first falling edge
	logic lf_prev_reg; // previous low-freq level
	logic gpin_s1_reg; // gate pin sync stage 1
	logic gpin_s2_reg; // gate pin sync stage 2
	logic [7:0] byte_prev_reg; // byte timer last value
	logic gsrc_prev_reg; // previous selected gate level
	logic toggle_reg; // gate toggle flip-flop
	logic [31:0] rdata_reg; // registered read data
	logic timer_on; // decoded control bits
	logic sync_off;
	logic gate_en;
	logic gate_pol;
	logic toggle_mode;
	logic [1:0] ps_sel;
	gtc_clk_src_type clk_src;
	gtc_gate_src_type gate_src;
	logic ext_level; // chosen external level
	logic ext_rise;
	logic ext_fall;
	logic src_tick; // one selected clock edge
	logic presc_tick; // prescaled edge
	logic gate_src_lvl; // selected gate source
	logic gate_value; // gate after toggle stage
	logic count_enable; // timer allowed to count
	logic inc; // the counter advances now
	logic byte_ovf_pulse; // byte timer rollover
	logic wr_en; // apb write accepted
	logic rd_setup; // apb read setup cycle
	logic wr_count; // write to either count byte
	logic ovf_clear; // software clears the flag
	logic [2:0] presc_last; // last prescale count

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// address decode used by both the write enable and the error answer
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == GTC_TIMER_CONTROL_OFS) ||
			(a == GTC_GATE_CONTROL_OFS) ||
			(a == GTC_COUNT_LOW_OFS) ||
			(a == GTC_COUNT_HIGH_OFS) ||
			(a == GTC_STATUS_OFS);
	endfunction : addr_mapped

	// prescale select to terminal count of the prescale counter
	function automatic logic [2:0] presc_limit(input logic [1:0] s);
		case (s)
			2'b00: presc_limit = 3'h0;
			2'b01: presc_limit = 3'h1;
			2'b10: presc_limit = 3'h3;
			default: presc_limit = 3'h7;
		endcase
	endfunction : presc_limit

	// ----------------------------------------------------------------
	// control field decode
	// ----------------------------------------------------------------
	assign timer_on = timer_control_reg[GTC_ON_POS];
	assign sync_off = timer_control_reg[GTC_SYNC_POS];
	assign ps_sel = timer_control_reg[GTC_PS_POS +: 2];
	assign clk_src = gtc_clk_src_type'(timer_control_reg[GTC_CS_POS +: 2]);
	assign gate_en = gate_control_reg[GTC_GE_POS];
	assign gate_pol = gate_control_reg[GTC_GPOL_POS];
	assign toggle_mode = gate_control_reg[GTC_GTM_POS];
	assign gate_src = gtc_gate_src_type'(gate_control_reg[GTC_GSS_POS +: 2]);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// zero wait states: the read word is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_mapped(paddr);
	assign wr_en = psel && penable && pwrite && addr_mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_count = wr_en &&
		((paddr == GTC_COUNT_LOW_OFS) || (paddr == GTC_COUNT_HIGH_OFS));
	assign ovf_clear = wr_en && (paddr == GTC_STATUS_OFS) &&
		pwdata[GTC_OVF_POS];
	assign prdata = rdata_reg;

	// read data register, unmapped reads give zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (clk_en && rd_setup) begin
			case (paddr)
				GTC_TIMER_CONTROL_OFS: begin
					rdata_reg <= {24'h00_0000, timer_control_reg};
				end
				GTC_GATE_CONTROL_OFS: begin
					rdata_reg <= {24'h00_0000, gate_control_reg[7:3],
						gate_value, gate_control_reg[1:0]};
				end
				GTC_COUNT_LOW_OFS: begin
					rdata_reg <= {24'h00_0000, count_reg[7:0]};
				end
				GTC_COUNT_HIGH_OFS: begin
					rdata_reg <= {24'h00_0000, count_reg[15:8]};
				end
				GTC_STATUS_OFS: begin
					rdata_reg <= {31'h0000_0000, ovf_reg};
				end
				default: begin
					rdata_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	// control registers; reserved bits are never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg <= GTC_CTRL_RESET;
			gate_control_reg <= GTC_CTRL_RESET;
		end else if (clk_en && wr_en) begin
			if (paddr == GTC_TIMER_CONTROL_OFS) begin
				timer_control_reg <= pwdata[7:0] & 8'hF5;
			end
			if (paddr == GTC_GATE_CONTROL_OFS) begin
				gate_control_reg <= pwdata[7:0] & 8'hE3;
			end
		end
	end

	// ----------------------------------------------------------------
	// external clock input capture
	// ----------------------------------------------------------------
	// the synchronised path costs two cycles of latency; the direct path
	// costs one, which is why a mode switch can gain or lose a count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_a_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			lf_prev_reg <= 1'b0;
		end else if (clk_en) begin
			ext_s1_reg <= external_clock_input;
			ext_s2_reg <= ext_s1_reg;
			ext_a_reg <= external_clock_input;
			ext_prev_reg <= ext_level;
			lf_prev_reg <= low_freq_internal_osc;
		end
	end

	// sync bit set takes the direct capture, bypassing the sync pair
	assign ext_level = sync_off ? ext_a_reg : ext_s2_reg;
	assign ext_rise = ext_level && !ext_prev_reg;
	assign ext_fall = !ext_level && ext_prev_reg;

	// first-falling-edge guard for counter mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			need_fall_reg <= 1'b1;
		end else if (clk_en) begin
			if (wr_count || !timer_on) begin
				need_fall_reg <= 1'b1;
			end else if (ext_fall) begin
				need_fall_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// clock source selection
	// ----------------------------------------------------------------
	// instruction clock phase runs free; it is pclk divided by four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_div_reg <= 2'h0;
		end else if (clk_en) begin
			instr_div_reg <= instr_div_reg + 2'h1;
		end
	end

	// one tick per selected clock edge; in sleep only the unsynchronised
	// external source keeps running
	always_comb begin
		src_tick = 1'b0;
		case (clk_src)
			GTC_CS_INSTR: begin
				src_tick = (instr_div_reg == GTC_INSTR_DIV_LAST) &&
					!sleep_mode;
			end
			GTC_CS_SYSTEM: begin
				src_tick = !sleep_mode;
			end
			GTC_CS_EXTERNAL: begin
				src_tick = ext_rise && !need_fall_reg &&
					(sync_off || !sleep_mode);
			end
			GTC_CS_LFOSC: begin
				src_tick = low_freq_internal_osc && !lf_prev_reg &&
					!sleep_mode;
			end
			default: begin
				src_tick = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	assign presc_last = presc_limit(ps_sel);
	assign presc_tick = src_tick && (presc_reg >= presc_last);

	// hidden divider; no register reaches it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= 3'h0;
		end else if (clk_en) begin
			if (wr_count) begin
				presc_reg <= 3'h0;
			end else if (presc_tick) begin
				presc_reg <= 3'h0;
			end else if (src_tick) begin
				presc_reg <= presc_reg + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// gate sources
	// ----------------------------------------------------------------
	// gate pin may change at any time, so it gets a synchroniser pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpin_s1_reg <= 1'b0;
			gpin_s2_reg <= 1'b0;
			byte_prev_reg <= GTC_BYTE_ZERO;
		end else if (clk_en) begin
			gpin_s1_reg <= gate_in.gate_pin;
			gpin_s2_reg <= gpin_s1_reg;
			byte_prev_reg <= gate_in.byte_timer_count;
		end
	end

	// one-cycle high pulse when the byte timer rolls over
	assign byte_ovf_pulse = (byte_prev_reg == GTC_BYTE_MAX) &&
		(gate_in.byte_timer_count == GTC_BYTE_ZERO);

	always_comb begin
		gate_src_lvl = 1'b0;
		case (gate_src)
			GTC_GS_PIN: gate_src_lvl = gpin_s2_reg;
			GTC_GS_BYTE_OVF: gate_src_lvl = byte_ovf_pulse;
			GTC_GS_CMP1: gate_src_lvl = gate_in.comparator1_output;
			GTC_GS_CMP2: gate_src_lvl = gate_in.comparator2_output;
			default: gate_src_lvl = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// gate toggle stage
	// ----------------------------------------------------------------
	// toggling on the rising edge of the source measures a whole period;
	// flipping polarity in the same write as enabling toggle is unsafe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gsrc_prev_reg <= 1'b0;
			toggle_reg <= 1'b0;
		end else if (clk_en) begin
			gsrc_prev_reg <= gate_src_lvl;
			if (!toggle_mode || !timer_on) begin
				toggle_reg <= 1'b0;
			end else if (gate_src_lvl && !gsrc_prev_reg) begin
				toggle_reg <= !toggle_reg;
			end
		end
	end

	assign gate_value = toggle_mode ? toggle_reg : gate_src_lvl;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// gate only matters with both on and gate enable set
	assign count_enable = timer_on &&
		(!gate_en || (gate_value == gate_pol));
	assign inc = count_enable && presc_tick;
	assign count_next = count_reg + 16'h0001;

	// a byte write wins over an increment in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= GTC_COUNT_RESET;
		end else if (clk_en) begin
			if (wr_en && (paddr == GTC_COUNT_LOW_OFS)) begin
				count_reg[7:0] <= pwdata[7:0];
			end else if (wr_en && (paddr == GTC_COUNT_HIGH_OFS)) begin
				count_reg[15:8] <= pwdata[7:0];
			end else if (inc) begin
				count_reg <= count_next;
			end
		end
	end

	// sticky overflow; a rollover in the clearing cycle keeps it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_reg <= 1'b0;
		end else if (clk_en) begin
			if (inc && !wr_count && (count_reg == GTC_COUNT_MAX)) begin
				ovf_reg <= 1'b1;
			end else if (ovf_clear) begin
				ovf_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign overflow_flag = ovf_reg;
	assign count_value = count_reg;

endmodule : gtc_timer

// File: bench/gtc_assertions.sv
// port checker for the gated timer: bus answers, counting, overflow flag
// assumes it is bound into gtc_timer and sees only that module's ports
`timescale 1ns/10ps
module gtc_checker
	import gtc_pkg::*;
(
	// clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// results
	input wire logic overflow_flag,
	input wire logic [15:0] count_value
);
	logic wr_en; // a write completing at this edge
	logic cnt_wr; // such a write to either count byte
	logic mapped; // address hits a register
	logic [7:0] ctrl_reg, gate_reg; // shadows of the two control words
	assign wr_en = psel && penable && pwrite && clk_en;
	assign cnt_wr = wr_en && (paddr == GTC_COUNT_LOW_OFS ||
		paddr == GTC_COUNT_HIGH_OFS);
	assign mapped = paddr inside {GTC_TIMER_CONTROL_OFS,
		GTC_GATE_CONTROL_OFS, GTC_COUNT_LOW_OFS, GTC_COUNT_HIGH_OFS,
		GTC_STATUS_OFS};
	// shadows follow bus writes, so a mode is known without the body
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 8'h00;
			gate_reg <= 8'h00;
		end else if (wr_en && paddr == GTC_TIMER_CONTROL_OFS) begin
			ctrl_reg <= pwdata[7:0];
		end else if (wr_en && paddr == GTC_GATE_CONTROL_OFS) begin
			gate_reg <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----
	// assertions
	// ----
	bus_ready_a: assert property (psel |-> pready)
		else $error("pready low during a transfer");
	bad_addr_a: assert property (pslverr == (psel && penable && !mapped))
		else $error("slave error does not match the address map");
	bad_read_zero_a: assert property (psel && !penable && !pwrite &&
		!mapped && clk_en |=> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	count_step_a: assert property ($past(!cnt_wr) &&
		$changed(count_value) |-> count_value == $past(count_value) + 16'h0001)
		else $error("counter moved by other than one");
	off_hold_a: assert property (!ctrl_reg[GTC_ON_POS] && !cnt_wr
		|=> $stable(count_value))
		else $error("counter moved while timer off");
	fast_count_a: assert property (ctrl_reg == 8'h41 &&
		!gate_reg[GTC_GE_POS] && !cnt_wr && clk_en
		|=> count_value == $past(count_value) + 16'h0001)
		else $error("system clock source missed a count");
	ovf_set_a: assert property ($past(count_value) == 16'hFFFF &&
		count_value == 16'h0000 |-> ##[0:1] overflow_flag)
		else $error("rollover did not set overflow flag");
	ovf_hold_a: assert property (overflow_flag && !(wr_en &&
		paddr == GTC_STATUS_OFS && pwdata[GTC_OVF_POS]) |=> overflow_flag)
		else $error("overflow flag dropped without a clear");
	ovf_cause_a: assert property ($rose(overflow_flag)
		|-> count_value <= 16'h0001)
		else $error("overflow flag rose away from rollover");
endmodule : gtc_checker

// File: bench/gtc_far_side.sv
// far side model: clock pin, slow oscillator, gate pin, comparators
// assumes pclk as timing reference; every change follows a rising edge
`timescale 1ns/10ps
module gtc_far_side
	import gtc_pkg::*;
(
	// timing reference
	input wire logic pclk,
	// sources toward the timer
	output logic external_clock_input,
	output logic low_freq_internal_osc,
	output gtc_gate_in_type gate_in
);
	logic [1:0] lf_ph; // slow oscillator phase
	initial begin
		external_clock_input = 1'b0;
		low_freq_internal_osc = 1'b0;
		gate_in = '0;
		lf_ph = 2'h0;
	end
	// slow oscillator free runs, eight cycle period
	always @(posedge pclk) begin
		lf_ph <= lf_ph + 2'h1;
		if (lf_ph == 2'h3)
			low_freq_internal_osc <= ~low_freq_internal_osc;
	end
	// gate levels; comparators are already synchronous
	task automatic set_gate(input logic pin, c1, c2);
		gate_in.gate_pin <= pin;
		gate_in.comparator1_output <= c1;
		gate_in.comparator2_output <= c2;
	endtask : set_gate
	// pin pulses idle low, four cycles per level so sync can see them
	task automatic ext_pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge pclk);
			external_clock_input <= 1'b1;
			repeat (4) @(posedge pclk);
			external_clock_input <= 1'b0;
		end
	endtask : ext_pulses
	// one byte timer rollover
	task automatic byte_roll();
		@(posedge pclk);
		gate_in.byte_timer_count <= 8'hFF;
		@(posedge pclk);
		gate_in.byte_timer_count <= 8'h00;
	endtask : byte_roll
endmodule : gtc_far_side

// File: bench/tb_gated_16bit_timer_counter.sv
// bench for the gated timer: APB master, far side model and scenarios
// assumes the checker is bound below and pclk runs at 40 MHz
`timescale 1ns/10ps
module tb_gated_16bit_timer_counter;
	import gtc_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] count_value, c0, d;
	logic sleep_mode, overflow_flag, rerr, ext_in, lf_osc;
	gtc_gate_in_type gate_in;
	int errors, checks;
	gtc_timer u_gtc_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_clock_input(ext_in),
		.low_freq_internal_osc(lf_osc), .sleep_mode(sleep_mode),
		.gate_in(gate_in), .overflow_flag(overflow_flag),
		.count_value(count_value));
	gtc_far_side u_gtc_far_side (.pclk(pclk), .external_clock_input(ext_in),
		.low_freq_internal_osc(lf_osc), .gate_in(gate_in));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic check(input string w, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// one transfer, entered just after a rising edge; waits for pready as
	// long as it takes (the watchdog bounds it), then lets one idle edge
	// pass so that a following setup never reassigns psel in this step
	task automatic apb(input logic is_wr, input logic [11:0] a,
		input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, string w);
		apb(1'b0, a, 32'h0000_0000);
		check(w, rdat, e);
	endtask : rd
	// counts over 64 cycles, once the gate path has settled
	task automatic measure(input logic [15:0] e);
		repeat (4) @(posedge pclk);
		#1 c0 = count_value;
		repeat (64) @(posedge pclk);
		#1 d = count_value - c0;
		check("count delta", {16'h0000, d}, {16'h0000, e});
		@(posedge pclk);
	endtask : measure
	task automatic s_reset();
		rd(GTC_TIMER_CONTROL_OFS, 32'h0000_0000, "control");
		rd(GTC_GATE_CONTROL_OFS, 32'h0000_0000, "gate control");
		rd(GTC_COUNT_HIGH_OFS, 32'h0000_0000, "count high");
		apb(1'b0, 12'h014, 32'h0000_0000);
		check("hole error", {31'h0000_0000, rerr}, 32'h0000_0001);
	endtask : s_reset
	task automatic s_rates();
		logic [1:0] cs;
		int dv;
		for (int k = 0; k < 3; k++)
			for (int p = 0; p < 4; p++) begin
				cs = (k == 0) ? 2'h1 : (k == 1) ? 2'h0 : 2'h3;
				dv = (k == 0) ? 1 : (k == 1) ? 4 : 8;
				wr(GTC_TIMER_CONTROL_OFS, {24'h00_0000, cs, 2'(p), 4'h1});
				measure(16'(64 / (dv << p)));
			end
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_0080);
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0040);
		measure(16'h0000);
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_0000);
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0041);
		clk_en <= 1'b0;
		measure(16'h0000);
		clk_en <= 1'b1;
	endtask : s_rates
	task automatic s_gate();
		logic [1:0] s;
		for (int k = 0; k < 3; k++)
			for (int v = 0; v < 4; v++) begin
				s = (k == 0) ? 2'h0 : 2'(k + 1);
				u_gtc_far_side.set_gate(s == 2'h0 && v[0], s == 2'h2 && v[0],
					s == 2'h3 && v[0]);
				wr(GTC_GATE_CONTROL_OFS, {24'h00_0000, 1'b1, v[1], 4'h0, s});
				measure((v[0] == v[1]) ? 16'h0040 : 16'h0000);
			end
		u_gtc_far_side.set_gate(1'b0, 1'b0, 1'b0);
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_00C1);
		@(posedge pclk);
		#1 c0 = count_value;
		u_gtc_far_side.byte_roll();
		repeat (6) @(posedge pclk);
		#1 d = count_value - c0;
		check("pulse count", {16'h0000, d}, 32'h0000_0001);
		@(posedge pclk);
	endtask : s_gate
	// one gate pin pulse; its rising edge flips the toggle stage
	task automatic pin_pulse();
		u_gtc_far_side.set_gate(1'b1, 1'b0, 1'b0);
		repeat (4) @(posedge pclk);
		u_gtc_far_side.set_gate(1'b0, 1'b0, 1'b0);
	endtask : pin_pulse
	task automatic s_toggle();
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_00E0);
		pin_pulse();
		measure(16'h0040);
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_00C0);
		measure(16'h0000);
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_00E0);
		measure(16'h0000);
		pin_pulse();
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0040);
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0041);
		measure(16'h0000);
	endtask : s_toggle
	// five pin pulses from low: the first rise is not counted, the first fall arms the counter
	task automatic s_ext();
		wr(GTC_GATE_CONTROL_OFS, 32'h0000_0000);
		for (int m = 0; m < 3; m++) begin
			wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0000);
			wr(GTC_COUNT_HIGH_OFS, 32'h0000_0000);
			wr(GTC_COUNT_LOW_OFS, 32'h0000_0000);
			sleep_mode <= (m == 2);
			wr(GTC_TIMER_CONTROL_OFS, {24'h00_0000, 5'h10, m != 0, 2'h1});
			u_gtc_far_side.ext_pulses(5);
			sleep_mode <= 1'b0;
			rd(GTC_COUNT_LOW_OFS, 32'h0000_0004, "pin count");
		end
	endtask : s_ext
	// a count byte write restarts the divide-by-eight phase, so the first
	// increment lands exactly eight system clocks after the write edge
	task automatic s_presc();
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0070);
		wr(GTC_COUNT_LOW_OFS, 32'h0000_0000);
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0071);
		#1 c0 = count_value;
		repeat (3) @(posedge pclk);
		#1 d = count_value - c0;
		check("prescale hold", {16'h0000, d}, 32'h0000_0000);
		@(posedge pclk);
		#1 d = count_value - c0;
		check("prescale step", {16'h0000, d}, 32'h0000_0001);
	endtask : s_presc
	task automatic s_ovf();
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0000);
		wr(GTC_COUNT_HIGH_OFS, 32'h0000_01FF);
		wr(GTC_COUNT_LOW_OFS, 32'h0000_00FD);
		rd(GTC_COUNT_HIGH_OFS, 32'h0000_00FF, "high byte");
		rd(GTC_COUNT_LOW_OFS, 32'h0000_00FD, "low byte");
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0041);
		repeat (8) @(posedge pclk);
		check("overflow", {31'h0000_0000, overflow_flag}, 32'h0000_0001);
		rd(GTC_STATUS_OFS, 32'h0000_0001, "status");
		wr(GTC_STATUS_OFS, 32'h0000_0001);
		@(posedge pclk);
		check("cleared", {31'h0000_0000, overflow_flag}, 32'h0000_0000);
		wr(GTC_TIMER_CONTROL_OFS, 32'h0000_0000);
	endtask : s_ovf
	initial begin
		errors = 0;
		checks = 0;
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sleep_mode = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_reset();
		s_rates();
		s_gate();
		s_toggle();
		s_ext();
		s_presc();
		s_ovf();
		report_and_stop();
	end
	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
endmodule : tb_gated_16bit_timer_counter
bind gtc_timer gtc_checker u_gtc_checker (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .overflow_flag(overflow_flag),
	.count_value(count_value));
